// [hw/spi_buf_pkg.sv]
// constants and carrier types for the serial buffer and flag block
package spi_buf_pkg;
	localparam int          DATA_W      = 8;
	localparam int          CNT_W       = 4;
	localparam logic [3:0]  ADDR_DATA   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_CTRL   = 4'h8;
	localparam int          ST_OVR      = 0;
	localparam int          ST_TXE      = 1;
	localparam int          ST_RXF      = 2;
	localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

	// software controls of the unit
	typedef struct packed {
		logic receive_full_irq_enable;
		logic transmit_empty_irq_enable;
		logic transmit_only_select;
		logic unit_enable_bit;
	} ctrl_s;

	localparam ctrl_s CTRL_RST = '0;

	// status as software sees it
	typedef struct packed {
		logic receive_full_flag;
		logic transmit_empty_flag;
		logic overrun_flag;
	} status_s;
endpackage

// [hw/spi_buffer_flag_control.sv]
// transmit buffer, shift register and receive buffer handoff with flags
`timescale 1ns/1ps
`default_nettype none

// Function
// - full duplex end: copy, set receive full, irq
// - end with receive buffer full: overrun, discard
// - transmit only: no copy, flags stay zero
// - write when transmit empty: store, clear flag
// - buffer to empty shift register, set flag, irq
// - busy shift register keeps new word buffered
// - transfer end empties shift register, reload
// - overrun still empties shift register at end
// - data read returns receive buffer, clears flag
// - write while transmit buffer full is lost
// - transmit irq gated by its enable
// - disabled unit with enable set raises irq
// - receive irq gated by its enable
// - flags show buffer states, irqs feed pending
// - overrun clears by status read then write zero
// - overrun blocks copy and receive irq
module spi_buffer_flag_control #(
	parameter int DATA_W = spi_buf_pkg::DATA_W
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial_clock_pin_i,
	input  wire logic        serial_select_n_i,
	input  wire logic        serial_data_in_i,
	output logic             serial_data_out_o,
	output logic             transmit_empty_irq_o,
	output logic             receive_full_irq_o
);
	spi_buf_pkg::ctrl_s   ctrl_r;
	spi_buf_pkg::status_s status_c;
	logic [DATA_W-1:0] tx_buf_r;
	logic [DATA_W-1:0] shift_r;
	logic [DATA_W-1:0] rx_buf_r;
	logic [DATA_W-1:0] shift_in;
	logic [spi_buf_pkg::CNT_W-1:0] bit_cnt_r;
	logic [2:0] sclk_sync_r;
	logic [1:0] sel_sync_r;
	logic [1:0] din_sync_r;
	logic tx_full_r;
	logic shift_full_r;
	logic rx_full_r;
	logic ovr_r;
	logic ovr_seen_r;
	logic ack_r;
	logic access;
	logic wr_data;
	logic rd_data;
	logic rd_status;
	logic wr_status;
	logic wr_ctrl;
	logic sclk_rise;
	logic active;
	logic done;
	logic load;
	logic rx_copy;

	// wishbone decode, effects taken on the request edge, ack next cycle
	assign access    = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_data   = access && wb_we_i && (wb_adr_i == spi_buf_pkg::ADDR_DATA)
		&& wb_sel_i[0];
	assign rd_data   = access && !wb_we_i && (wb_adr_i == spi_buf_pkg::ADDR_DATA);
	assign rd_status = access && !wb_we_i
		&& (wb_adr_i == spi_buf_pkg::ADDR_STATUS);
	assign wr_status = access && wb_we_i
		&& (wb_adr_i == spi_buf_pkg::ADDR_STATUS) && wb_sel_i[0];
	assign wr_ctrl   = access && wb_we_i && (wb_adr_i == spi_buf_pkg::ADDR_CTRL)
		&& wb_sel_i[0];
	assign wb_ack_o  = ack_r;

	// flags exactly as software reads them
	assign status_c.receive_full_flag   = rx_full_r;
	assign status_c.transmit_empty_flag = !tx_full_r;
	assign status_c.overrun_flag        = ovr_r;

	// link pins pass two flops before use; third stage only for edges
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sclk_sync_r <= '0;
			sel_sync_r  <= '1;
			din_sync_r  <= '0;
		end
		else
		begin
			sclk_sync_r <= {sclk_sync_r[1:0], serial_clock_pin_i};
			sel_sync_r  <= {sel_sync_r[0], serial_select_n_i};
			din_sync_r  <= {din_sync_r[0], serial_data_in_i};
		end
	end

	assign sclk_rise = sclk_sync_r[1] && !sclk_sync_r[2];
	assign active    = !sel_sync_r[1] && ctrl_r.unit_enable_bit;
	assign shift_in  = {shift_r[DATA_W-2:0], din_sync_r[1]};
	// a word ends on its last synced rising edge
	assign done      = active && sclk_rise
		&& (bit_cnt_r == spi_buf_pkg::CNT_W'(DATA_W - 1));
	// reload only between words, so a word in flight is never replaced
	assign load      = tx_full_r && !shift_full_r && (bit_cnt_r == '0)
		&& !(active && sclk_rise);
	// overrun or transmit-only leaves the receive side untouched
	assign rx_copy   = done && !ctrl_r.transmit_only_select
		&& !rx_full_r && !ovr_r;

	// bus acknowledge and registered read data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r    <= 1'b0;
			wb_dat_o <= spi_buf_pkg::RD_ZERO;
		end
		else
		begin
			ack_r <= access;
			if (rd_data)
				wb_dat_o <= 32'(rx_buf_r);
			else if (rd_status)
				wb_dat_o <= 32'(status_c);
			else if (access && !wb_we_i
				&& wb_adr_i == spi_buf_pkg::ADDR_CTRL)
				wb_dat_o <= 32'(ctrl_r);
			else
				wb_dat_o <= spi_buf_pkg::RD_ZERO;
		end
	end

	// control register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_r <= spi_buf_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= spi_buf_pkg::ctrl_s'(wb_dat_i[3:0]);
	end

	// transmit buffer; a write while full is dropped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_buf_r  <= '0;
			tx_full_r <= 1'b0;
		end
		else if (load)
			tx_full_r <= 1'b0;
		// a write racing a load still sees a full buffer and is lost
		else if (wr_data && !tx_full_r)
		begin
			tx_buf_r  <= wb_dat_i[DATA_W-1:0];
			tx_full_r <= 1'b1;
		end
	end

	// shift register and bit counter; msb goes out first
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			shift_r      <= '0;
			shift_full_r <= 1'b0;
			bit_cnt_r    <= '0;
		end
		// idle link: counter parked, reload allowed
		else if (!active)
		begin
			bit_cnt_r <= '0;
			if (load)
			begin
				shift_r      <= tx_buf_r;
				shift_full_r <= 1'b1;
			end
		end
		else if (sclk_rise)
		begin
			// an unloaded word resends what was last shifted in
			shift_r <= shift_in;
			if (done)
			begin
				bit_cnt_r    <= '0;
				shift_full_r <= 1'b0;
			end
			else
				bit_cnt_r <= bit_cnt_r + 1'b1;
		end
		else if (load)
		begin
			shift_r      <= tx_buf_r;
			shift_full_r <= 1'b1;
		end
	end

	// msb straight from the flop, no extra output stage
	assign serial_data_out_o = shift_r[DATA_W-1];

	// receive buffer; a new word sets the flag even against a read
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_buf_r  <= '0;
			rx_full_r <= 1'b0;
		end
		else if (rx_copy)
		begin
			rx_buf_r  <= shift_in;
			rx_full_r <= 1'b1;
		end
		else if (rd_data)
			rx_full_r <= 1'b0;
	end

	// overrun: set wins, clear needs a status read seen with flag set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ovr_r      <= 1'b0;
			ovr_seen_r <= 1'b0;
		end
		else
		begin
			if (done && !ctrl_r.transmit_only_select && rx_full_r)
				ovr_r <= 1'b1;
			else if (wr_status && ovr_seen_r && !wb_dat_i[spi_buf_pkg::ST_OVR])
				ovr_r <= 1'b0;
			// the read must be seen with the flag already set
			if (rd_status && ovr_r)
				ovr_seen_r <= 1'b1;
			else if (!ovr_r)
				ovr_seen_r <= 1'b0;
		end
	end

	// interrupt requests, one-cycle pulses except the disabled-unit level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			transmit_empty_irq_o <= 1'b0;
			receive_full_irq_o   <= 1'b0;
		end
		else
		begin
			transmit_empty_irq_o <= ctrl_r.transmit_empty_irq_enable
				&& (load || !ctrl_r.unit_enable_bit);
			receive_full_irq_o <= ctrl_r.receive_full_irq_enable
				&& rx_copy;
		end
	end

	// rule checks, all on the block clock
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_RX_COPY: assert property (rx_copy |=> rx_full_r
		&& rx_buf_r == $past(shift_in))
		else $error("received word not copied");
	AST_OVR_SET: assert property (done && rx_full_r
		&& !ctrl_r.transmit_only_select |=> ovr_r && $stable(rx_buf_r))
		else $error("overrun not flagged");
	AST_TX_ONLY: assert property (done && ctrl_r.transmit_only_select
		&& !rx_full_r && !ovr_r |=> !rx_full_r && !ovr_r)
		else $error("transmit only mode touched receive side");
	AST_WR_TAKE: assert property (wr_data && !tx_full_r
		|=> tx_full_r && tx_buf_r == $past(wb_dat_i[DATA_W-1:0]))
		else $error("write to empty buffer not taken");
	AST_LOAD: assert property (load |=> shift_full_r
		&& !tx_full_r && shift_r == $past(tx_buf_r))
		else $error("buffer not moved to shift register");
	AST_HOLD_BUSY: assert property (tx_full_r && shift_full_r
		&& !done |=> tx_full_r)
		else $error("buffered word left while shift busy");
	AST_END_RELOAD: assert property (done && tx_full_r
		&& !rst_i |=> !shift_full_r ##1 shift_full_r || active)
		else $error("shift register not reloaded after end");
	AST_RD_CLR: assert property (rd_data && !done |=> !rx_full_r)
		else $error("data read did not clear receive flag");
	AST_WR_DROP: assert property (wr_data && tx_full_r && !load
		|=> $stable(tx_buf_r) && tx_full_r)
		else $error("write to full buffer changed it");
	AST_TXIRQ_GATE: assert property (!ctrl_r.transmit_empty_irq_enable
		|=> !transmit_empty_irq_o)
		else $error("transmit irq without enable");
	AST_TXIRQ_OFF: assert property (!ctrl_r.unit_enable_bit
		&& ctrl_r.transmit_empty_irq_enable |=> transmit_empty_irq_o)
		else $error("disabled unit gave no transmit irq");
	AST_RXIRQ_GATE: assert property (!ctrl_r.receive_full_irq_enable
		|=> !receive_full_irq_o)
		else $error("receive irq without enable");
	AST_OVR_HOLD: assert property (ovr_r && !wr_status |=> ovr_r)
		else $error("overrun cleared without write");
	AST_OVR_BLOCK: assert property (done && ovr_r
		|=> !receive_full_irq_o && $stable(rx_buf_r))
		else $error("overrun did not block copy");

	// irq pulses, reset state, read paths, overrun clearing and shift emptying on overrun
	AST_RESET_EMPTY: assert property ($fell(rst_i)
		|-> !tx_full_r && !shift_full_r && !rx_full_r && !ovr_r)
		else $error("buffers not empty after reset");
	AST_RX_IRQ: assert property (rx_copy
		&& ctrl_r.receive_full_irq_enable |=> receive_full_irq_o)
		else $error("receive irq missing on copy");
	AST_TX_IRQ: assert property (load
		&& ctrl_r.transmit_empty_irq_enable |=> transmit_empty_irq_o)
		else $error("transmit irq missing on load");
	AST_RD_DATA: assert property (rd_data
		|=> wb_dat_o[DATA_W-1:0] == $past(rx_buf_r))
		else $error("data read returned wrong word");
	AST_OVR_CLEAR: assert property (wr_status && ovr_seen_r
		&& !wb_dat_i[spi_buf_pkg::ST_OVR] && !done |=> !ovr_r)
		else $error("overrun not cleared by write");
	AST_SHIFT_EMPTY: assert property (done && ovr_r
		|=> !shift_full_r)
		else $error("overrun kept shift register full");
	AST_STATUS_VIEW: assert property (rd_status
		|=> wb_dat_o[spi_buf_pkg::ST_RXF] == $past(rx_full_r)
		&& wb_dat_o[spi_buf_pkg::ST_TXE] == !$past(tx_full_r)
		&& wb_dat_o[spi_buf_pkg::ST_OVR] == $past(ovr_r))
		else $error("status read does not match buffers");

	// main scenarios worth seeing at least once
	COV_COPY: cover property (rx_copy);
	COV_OVERRUN: cover property (done && rx_full_r && !ovr_r);
	COV_RELOAD: cover property (done && tx_full_r ##[1:4] load);
	COV_OVR_CLEAR: cover property (rd_status && ovr_r ##[1:20] !ovr_r);
	COV_TX_ONLY: cover property (done && ctrl_r.transmit_only_select);
endmodule

`default_nettype wire

// [tb/spi_buffer_flag_control_tb.sv]
// bench: bus and link sequences against the buffer and flag block
`timescale 1ns/1ps
`default_nettype none
module spi_buffer_flag_control_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic        sclk;
	logic        sel_n;
	logic        mosi;
	logic        miso;
	logic        txe_irq;
	logic        rxf_irq;
	logic        txe_q = 1'b0;
	logic [31:0] rd;
	logic [7:0]  rx;
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;
	int          txe_n = 0;
	int          rxf_n = 0;

	always #2.5 clk_i = ~clk_i;

	spi_buffer_flag_control dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .serial_clock_pin_i(sclk),
		.serial_select_n_i(sel_n), .serial_data_in_i(mosi),
		.serial_data_out_o(miso), .transmit_empty_irq_o(txe_irq),
		.receive_full_irq_o(rxf_irq));

	spi_master_model pm_u (.sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi),
		.miso_i(miso));

	// irq pulse counts and the hang guard
	always @(posedge clk_i)
	begin
		txe_q <= txe_irq;
		if (txe_irq === 1'b1 && txe_q !== 1'b1)
			txe_n <= txe_n + 1;
		if (rxf_irq === 1'b1)
			rxf_n <= rxf_n + 1;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle; waits for ack however long it takes
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic wd(input logic [7:0] d);
		bus(1'b1, spi_buf_pkg::ADDR_DATA, {24'h0, d});
	endtask

	task automatic wc(input logic [3:0] d);
		bus(1'b1, spi_buf_pkg::ADDR_CTRL, {28'h0, d});
	endtask

	task automatic ws(input logic [2:0] d);
		bus(1'b1, spi_buf_pkg::ADDR_STATUS, {29'h0, d});
	endtask

	// status bits: 2 receive full, 1 transmit empty, 0 overrun
	task automatic st(input logic [2:0] e);
		bus(1'b0, spi_buf_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("status", rd, {29'h0, e});
	endtask

	task automatic dr(input logic [7:0] e);
		bus(1'b0, spi_buf_pkg::ADDR_DATA, 32'h0000_0000);
		chk("data", rd, {24'h0, e});
	endtask

	// a frame ends off the clock grid, so realign before the next cycle
	task automatic link(input logic [7:0] tx, input logic [7:0] e);
		pm_u.xfer(tx, rx);
		@(posedge clk_i);
		chk("miso", {24'h0, rx}, {24'h0, e});
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		st(3'h2);
		bus(1'b0, 4'hC, 32'h0000_0000);
		chk("unmapped", rd, spi_buf_pkg::RD_ZERO);
		wc(4'h4);
		chk("txe_irq", {31'h0, txe_irq}, 32'h0000_0001);
		wc(4'hD);
		bus(1'b0, spi_buf_pkg::ADDR_CTRL, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_000D);
		wd(8'hA5);
		wd(8'h3C);
		wd(8'h77);
		st(3'h0);
		link(8'h96, 8'hA5);
		st(3'h6);
		dr(8'h96);
		wd(8'h55);
		link(8'h11, 8'h3C);
		wd(8'h66);
		link(8'h22, 8'h55);
		ws(3'h0);
		st(3'h7);
		dr(8'h11);
		st(3'h3);
		ws(3'h0);
		st(3'h2);
		wc(4'h3);
		wd(8'h44);
		link(8'h33, 8'h66);
		st(3'h2);
		dr(8'h11);
		wc(4'h1);
		link(8'h5A, 8'h44);
		st(3'h6);
		dr(8'h5A);
		chk("txe_irqs", txe_n, 5);
		chk("rxf_irqs", rxf_n, 2);
		close_out();
	end
endmodule
`default_nettype wire

// [tb/spi_master_model.sv]
// remote serial master that clocks one word out and in per frame
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	output logic      sclk_o,
	output logic      sel_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// link idles deselected with its clock parked low
	initial
	begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// msb first, sampled on the rising edge at 64 ns per bit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		sel_n_o <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			mosi_o <= tx[i];
			#32 sclk_o <= 1'b1;
			rx[i] = miso_i;
			#32 sclk_o <= 1'b0;
		end
		#32 sel_n_o <= 1'b1;
		mosi_o <= ~tx[0]; // released line must not look like a held bit
	endtask
endmodule
`default_nettype wire
